/* core/cvc_core.sv */
// Vertical counters, cursor, start address, light pen latch and indexed host access of the CRT timing block.
// Assumes line_tick and char_tick come from horizontal timing on ref_clk; the pen strobe is asynchronous.
`include "cvc_regs.svh"

module cvc_core
  import cvc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Host indexed port
  input  wire logic        host_index_wr,
  input  wire logic        host_data_wr,
  input  wire logic        host_data_rd,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata_q,
  // Settings held by neighbouring registers
  input  wire logic        mode_byte_mode,
  input  wire logic        ext_enable,
  input  wire logic        dbl_start_byte,
  input  wire logic        dbl_width_lsb_n,
  input  wire logic [7:0]  vtotal_low,
  input  wire logic [7:0]  line_compare_low,
  // Horizontal timing events
  input  wire logic        line_tick,
  input  wire logic        char_tick,
  // Light pen pin
  input  wire logic        light_pen_strobe,
  // Display timing outputs
  output logic             vertical_retrace_pulse_q,
  output logic             frame_interrupt_output_q,
  output logic             vblank_q,
  output logic             vdisp_q,
  output logic      [4:0]  row_scan_q,
  output logic      [8:0]  scan_line_q,
  output logic      [15:0] mem_addr_q,
  output logic             cursor_hit_q,
  output logic      [1:0]  cursor_skew_q,
  output logic             underline_hit_q
);

  // The address path is fixed at sixteen bits by the register pairs
  initial begin
    if (ADDR_W != 16) begin
      $error("cvc_core supports only ADDR_W of 16");
    end
  end

  // Nine-bit comparison value from a low byte and an overflow bit
  function automatic logic [8:0] nine_bit(input logic [7:0] low, input logic top);
    nine_bit = {top, low};
  endfunction : nine_bit

  // Skew code to character clocks; codes 00 and 01 both give one
  function automatic logic [1:0] skew_of(input logic [1:0] code);
    skew_of = (code == 2'b00) ? 2'h1 : code;
  endfunction : skew_of

  cvc_state_type q;
  cvc_state_type d;

  logic [8:0]  vtotal9;
  logic [8:0]  vrs9;
  logic [8:0]  vbs9;
  logic [8:0]  vde9;
  logic [8:0]  lcmp9;
  logic        frame_wrap;
  logic        row_wrap;
  logic        retrace_set;
  logic        pen_edge;
  logic [8:0]  width9;
  logic [15:0] row_step;
  logic [15:0] frame_start;

  // Nine-bit compare values and derived events
  always_comb begin
    vtotal9     = nine_bit(vtotal_low, q.overflow[`CVC_OVF_VTOTAL]);
    vrs9        = nine_bit(q.vrs, q.overflow[`CVC_OVF_VRS]);
    vbs9        = nine_bit(q.vblank_start, q.overflow[`CVC_OVF_VBLANK]);
    vde9        = nine_bit(q.vdisp_end, q.overflow[`CVC_OVF_VDISP]);
    lcmp9       = nine_bit(line_compare_low, q.overflow[`CVC_OVF_LCMP]);
    frame_wrap  = line_tick && (q.scan == vtotal9);
    row_wrap    = line_tick && !frame_wrap && (q.row == q.max_scan[4:0]);
    retrace_set = line_tick && !frame_wrap && ((q.scan + 9'h001) == vrs9);
    pen_edge    = q.pen_s2 && !q.pen_s3;
    // Half-step of width only exists with extended registers on
    width9      = {q.offset, ext_enable ? !dbl_width_lsb_n : 1'b0};
    // Word mode adds four per unit, byte mode two
    row_step    = mode_byte_mode ? {7'h00, width9} : {6'h00, width9, 1'b0};
    // Word start address becomes a byte address unless byte resolution is on
    frame_start = (ext_enable && dbl_start_byte) ? {q.start_hi, q.start_lo}
                                                 : {q.start_hi[6:0], q.start_lo, 1'b0};
  end

  // Next state of the whole core
  always_comb begin
    d = q;

    // Host address and data ports
    if (host_index_wr) begin
      d.index        = ext_enable ? host_wdata : {3'h0, host_wdata[4:0]};
      d.idx_top_ones = host_wdata[7] && host_wdata[6];
    end
    if (host_data_wr) begin
      unique case (q.index)
        `CVC_IDX_OVERFLOW:   d.overflow     = host_wdata;
        `CVC_IDX_PRESET:     d.preset       = host_wdata;
        `CVC_IDX_MAXSCAN:    d.max_scan     = host_wdata;
        `CVC_IDX_CUR_START:  d.cur_start    = host_wdata;
        `CVC_IDX_CUR_END:    d.cur_end      = host_wdata;
        `CVC_IDX_START_HI:   d.start_hi     = host_wdata;
        `CVC_IDX_START_LO:   d.start_lo     = host_wdata;
        `CVC_IDX_CUR_HI:     d.cur_hi       = host_wdata;
        `CVC_IDX_CUR_LO:     d.cur_lo       = host_wdata;
        `CVC_IDX_VRS_PEN_HI: d.vrs          = host_wdata;
        `CVC_IDX_VRE_PEN_LO: d.vre          = host_wdata;
        `CVC_IDX_VDISP_END:  d.vdisp_end    = host_wdata;
        `CVC_IDX_OFFSET:     d.offset       = host_wdata;
        `CVC_IDX_UNDERLINE:  d.underline    = host_wdata;
        `CVC_IDX_VBLANK:     d.vblank_start = host_wdata;
        default:             d.overflow     = q.overflow;
      endcase
    end

    // Read data is registered one cycle after the strobe
    if (host_data_rd) begin
      unique case (q.index)
        `CVC_IDX_OVERFLOW:   d.rdata = q.overflow;
        `CVC_IDX_PRESET:     d.rdata = q.preset;
        `CVC_IDX_MAXSCAN:    d.rdata = q.max_scan;
        `CVC_IDX_CUR_START:  d.rdata = q.cur_start;
        `CVC_IDX_CUR_END:    d.rdata = q.cur_end;
        `CVC_IDX_START_HI:   d.rdata = q.start_hi;
        `CVC_IDX_START_LO:   d.rdata = q.start_lo;
        `CVC_IDX_CUR_HI:     d.rdata = q.cur_hi;
        `CVC_IDX_CUR_LO:     d.rdata = q.cur_lo;
        `CVC_IDX_VRS_PEN_HI: d.rdata = ext_enable ? q.vrs : q.pen[15:8];
        `CVC_IDX_VRE_PEN_LO: d.rdata = ext_enable ? q.vre : q.pen[7:0];
        `CVC_IDX_VDISP_END:  d.rdata = q.vdisp_end;
        `CVC_IDX_OFFSET:     d.rdata = q.offset;
        `CVC_IDX_UNDERLINE:  d.rdata = q.underline;
        `CVC_IDX_VBLANK:     d.rdata = q.vblank_start;
        default:             d.rdata = 8'h00;
      endcase
    end

    // Scan line counter wraps at the nine-bit vertical total
    if (line_tick) begin
      d.scan = frame_wrap ? 9'h000 : q.scan + 9'h001;
    end

    // Row scan counter: preset at frame start, clear at maximum
    if (frame_wrap) begin
      d.row = q.preset[4:0];
    end else if (row_wrap) begin
      d.row = 5'h00;
    end else if (line_tick) begin
      d.row = q.row + 5'h01;
    end

    // Row start and running address; split screen forces zero
    if (frame_wrap) begin
      d.row_start = frame_start;
      d.addr      = frame_start;
    end else if (line_tick && ((q.scan + 9'h001) == lcmp9)) begin
      d.row_start = 16'h0000;
      d.addr      = 16'h0000;
    end else if (row_wrap) begin
      d.row_start = q.row_start + row_step;
      d.addr      = q.row_start + row_step;
    end else if (line_tick) begin
      d.addr      = q.row_start;
    end else if (char_tick) begin
      d.addr      = q.addr + 16'h0001;
    end

    // Word mode rotates the top bit onto the lowest address line
    d.mem_addr = mode_byte_mode ? d.addr : {d.addr[14:0], d.addr[15]};

    // Retrace: starts at the nine-bit match, ends on four-bit match
    if (retrace_set) begin
      d.vertical_retrace_pulse = 1'b1;
    end else if (line_tick && q.vertical_retrace_pulse && ((q.scan[3:0] + 4'h1) == q.vre[3:0])) begin
      d.vertical_retrace_pulse = 1'b0;
    end

    // Interrupt: a new retrace start wins over a held clear
    d.irq = (retrace_set && !q.vre[`CVC_VRE_EN_N]) ||
            (q.irq && q.vre[`CVC_VRE_CLR_N]);

    // Blanking begins at its start line and ends with the frame
    if (frame_wrap) begin
      d.vblank = 1'b0;
    end else if (line_tick && ((q.scan + 9'h001) == vbs9)) begin
      d.vblank = 1'b1;
    end
    d.vdisp = (d.scan <= vde9);

    // Cursor shape, position and skew
    d.cursor_hit  = (d.row >= q.cur_start[4:0]) &&
                    (({1'b0, d.row} + 6'h01) <= {1'b0, q.cur_end[4:0]}) &&
                    (d.addr == {q.cur_hi[6:0], q.cur_lo, 1'b0});
    d.cursor_skew = skew_of(q.cur_end[`CVC_CUR_SKEW_LSB +: 2]);
    // The register holds one less than the line; software keeps that offset
    d.underline_hit = (d.row == q.underline[4:0]);

    // Light pen strobe synchroniser and latch
    d.pen_s1 = light_pen_strobe;
    d.pen_s2 = q.pen_s1;
    d.pen_s3 = q.pen_s2;
    if (pen_edge) begin
      d.pen = q.addr;
    end
  end

  // Single state register; reset gives constants only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q              <= '0;
      q.overflow     <= `CVC_REG_RESET;
      q.vre          <= `CVC_REG_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register
  always_comb begin
    host_rdata_q             = q.rdata;
    vertical_retrace_pulse_q = q.vertical_retrace_pulse;
    frame_interrupt_output_q = q.irq;
    vblank_q                 = q.vblank;
    vdisp_q                  = q.vdisp;
    row_scan_q               = q.row;
    scan_line_q              = q.scan;
    mem_addr_q               = q.mem_addr;
    cursor_hit_q             = q.cursor_hit;
    cursor_skew_q            = q.cursor_skew;
    underline_hit_q          = q.underline_hit;
  end

  // Retrace rises only on the programmed nine-bit line
  retrace_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(q.vertical_retrace_pulse) |-> (q.scan == vrs9))
    else $error("retrace rose on wrong scan line");

  // Retrace falls only when the four low bits match
  retrace_end_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(q.vertical_retrace_pulse) |-> (q.scan[3:0] == q.vre[3:0]))
    else $error("retrace fell on wrong scan line");

  // Enabled retrace start raises the interrupt
  irq_raise_a: assert property (@(posedge ref_clk) disable iff (reset)
    (retrace_set && !q.vre[`CVC_VRE_EN_N]) |=> (q.irq && q.vertical_retrace_pulse))
    else $error("interrupt not raised at retrace start");

  // Clear bit low drops the interrupt when no new start arrives
  irq_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!q.vre[`CVC_VRE_CLR_N] && !retrace_set) |=> !q.irq)
    else $error("interrupt not cleared");

  // Row counter clears after the maximum line
  row_wrap_a: assert property (@(posedge ref_clk) disable iff (reset)
    row_wrap |=> (q.row == 5'h00))
    else $error("row counter did not clear at maximum");

  // Frame start loads the preset row and start address
  preset_load_a: assert property (@(posedge ref_clk) disable iff (reset)
    frame_wrap |=> ((q.row == $past(q.preset[4:0])) && (q.row_start == $past(frame_start))))
    else $error("frame start did not load preset and start address");

  // Each new character row off the split-screen line steps by the computed width
  row_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    (row_wrap && ((q.scan + 9'h001) != lcmp9)) |=> (q.row_start == $past(q.row_start) + $past(row_step)))
    else $error("row start did not advance by width");

  // Pen edge captures the running address at the very next edge
  pen_latch_a: assert property (@(posedge ref_clk) disable iff (reset)
    pen_edge |=> (q.pen == $past(q.addr)))
    else $error("light pen address not latched");

  // Non-extended read of index 10h returns the pen high byte
  pen_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    (host_data_rd && !ext_enable && (q.index == `CVC_IDX_VRS_PEN_HI)) |=> (host_rdata_q == $past(q.pen[15:8])))
    else $error("index 10h read returned wrong byte");

endmodule : cvc_core

/* core/cvc_pkg.sv */
// Types shared by the vertical and cursor timing block.
// Assumes the register header is included where indices are needed.
package cvc_pkg;

  // Whole state of the core, registered as one word
  typedef struct packed {
    logic [7:0]  index;
    logic        idx_top_ones;
    logic [7:0]  overflow;
    logic [7:0]  preset;
    logic [7:0]  max_scan;
    logic [7:0]  cur_start;
    logic [7:0]  cur_end;
    logic [7:0]  start_hi;
    logic [7:0]  start_lo;
    logic [7:0]  cur_hi;
    logic [7:0]  cur_lo;
    logic [7:0]  vrs;
    logic [7:0]  vre;
    logic [7:0]  vdisp_end;
    logic [7:0]  offset;
    logic [7:0]  underline;
    logic [7:0]  vblank_start;
    logic [8:0]  scan;
    logic [4:0]  row;
    logic [15:0] row_start;
    logic [15:0] addr;
    logic [15:0] pen;
    logic        pen_s1;
    logic        pen_s2;
    logic        pen_s3;
    logic        vertical_retrace_pulse;
    logic        irq;
    logic        vblank;
    logic        vdisp;
    logic        cursor_hit;
    logic        underline_hit;
    logic [1:0]  cursor_skew;
    logic [7:0]  rdata;
    logic [15:0] mem_addr;
  } cvc_state_type;

endpackage : cvc_pkg

/* core/cvc_regs.svh */
// Register indices, field positions and reset values of the vertical and cursor part of the CRT timing block.
// Assumes the including file is compiled in one clock domain; definitions only.
`ifndef CVC_REGS_SVH
`define CVC_REGS_SVH

// Register indices behind the data port
`define CVC_IDX_OVERFLOW   8'h07
`define CVC_IDX_PRESET     8'h08
`define CVC_IDX_MAXSCAN    8'h09
`define CVC_IDX_CUR_START  8'h0a
`define CVC_IDX_CUR_END    8'h0b
`define CVC_IDX_START_HI   8'h0c
`define CVC_IDX_START_LO   8'h0d
`define CVC_IDX_CUR_HI     8'h0e
`define CVC_IDX_CUR_LO     8'h0f
`define CVC_IDX_VRS_PEN_HI 8'h10
`define CVC_IDX_VRE_PEN_LO 8'h11
`define CVC_IDX_VDISP_END  8'h12
`define CVC_IDX_OFFSET     8'h13
`define CVC_IDX_UNDERLINE  8'h14
`define CVC_IDX_VBLANK     8'h15

// Ninth-bit positions inside the overflow register
`define CVC_OVF_VTOTAL     0
`define CVC_OVF_VDISP      1
`define CVC_OVF_VRS        2
`define CVC_OVF_VBLANK     3
`define CVC_OVF_LCMP       4

// Field positions in cursor end and retrace end
`define CVC_CUR_SKEW_LSB   5
`define CVC_VRE_CLR_N      4
`define CVC_VRE_EN_N       5

// Reset value of every writable register
`define CVC_REG_RESET      8'h00

`endif

/* tb/cvc_core_tb.sv */
// Self-checking bench for the vertical and cursor timing core.
// Assumes cvc_pkg is compiled first and the line model file sits beside this one.
module cvc_core_tb
  import cvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus, all given a value at time zero
  logic        ref_clk = 1'b0, reset = 1'b1, run = 1'b1, pen_req = 1'b0;
  logic        host_index_wr = 1'b0, host_data_wr = 1'b0, host_data_rd = 1'b0;
  logic [7:0]  host_wdata = 8'h00, vtotal_low = 8'h1e, line_compare_low = 8'hff;
  logic        mode_byte_mode = 1'b1, ext_enable = 1'b0, dbl_start_byte = 1'b0, dbl_width_lsb_n = 1'b1;
  // Observed signals
  logic        line_tick, char_tick, light_pen_strobe, vertical_retrace_pulse_q, frame_interrupt_output_q;
  logic        vblank_q, vdisp_q, cursor_hit_q, underline_hit_q;
  logic [7:0]  host_rdata_q;
  logic [4:0]  row_scan_q;
  logic [8:0]  scan_line_q;
  logic [15:0] mem_addr_q;
  logic [1:0]  cursor_skew_q;
  // Expectation queues and bookkeeping
  logic        rd_d1 = 1'b0, rd_d2 = 1'b0, vr_prev = 1'b0;
  logic [7:0]  q_rd[$];
  logic [16:0] q_rise[$], q_fall[$];
  logic [7:0]  d;
  int          n_fail = 0, checks_done = 0, cycles = 0;
  integer      seed = 32'h156f;

  cvc_core cvc_core_i (.ref_clk, .reset, .host_index_wr, .host_data_wr, .host_data_rd, .host_wdata,
    .host_rdata_q, .mode_byte_mode, .ext_enable, .dbl_start_byte, .dbl_width_lsb_n, .vtotal_low,
    .line_compare_low, .line_tick, .char_tick, .light_pen_strobe, .vertical_retrace_pulse_q,
    .frame_interrupt_output_q, .vblank_q, .vdisp_q, .row_scan_q, .scan_line_q, .mem_addr_q,
    .cursor_hit_q, .cursor_skew_q, .underline_hit_q);

  cvc_hsync_model cvc_hsync_model_i (.ref_clk, .run, .pen_req, .line_tick, .char_tick, .light_pen_strobe);

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_frame(input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_frame

  // Index write, then data write; entered just after a rising edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    host_index_wr <= 1'b1;
    host_wdata <= idx;
    @(posedge ref_clk);
    host_index_wr <= 1'b0;
    host_data_wr <= 1'b1;
    host_wdata <= val;
    @(posedge ref_clk);
    host_data_wr <= 1'b0;
  endtask : wr

  // Index write, then data read; the watcher checks the answer
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host_index_wr <= 1'b1;
    host_wdata <= idx;
    @(posedge ref_clk);
    host_index_wr <= 1'b0;
    host_data_rd <= 1'b1;
    q_rd.push_back(exp);
    @(posedge ref_clk);
    host_data_rd <= 1'b0;
  endtask : rd

  task automatic wait_vr(input logic lvl);
    @(posedge ref_clk);
    while (vertical_retrace_pulse_q !== lvl) @(posedge ref_clk);
  endtask : wait_vr

  // Read answer lands one edge after the read is taken
  always @(posedge ref_clk) begin
    rd_d1 <= host_data_rd;
    rd_d2 <= rd_d1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      test_done();
    end
  end

  // Watcher: compare results at the falling edge, where everything has settled
  always @(negedge ref_clk) begin
    if (rd_d2 && q_rd.size() > 0) chk_rd(q_rd.pop_front(), host_rdata_q);
    if (vertical_retrace_pulse_q === 1'b1 && vr_prev === 1'b0 && q_rise.size() > 0)
      chk_frame(q_rise.pop_front(), {scan_line_q, row_scan_q, frame_interrupt_output_q, vblank_q, vdisp_q});
    if (vertical_retrace_pulse_q === 1'b0 && vr_prev === 1'b1 && q_fall.size() > 0)
      chk_frame(q_fall.pop_front(), {13'h0, scan_line_q[3:0]});
    vr_prev = vertical_retrace_pulse_q;
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Plain registers read back what was written; pen bytes and unmapped index read zero
    for (int i = 7; i <= 8'h15; i++) begin
      if (i == 8'h10 || i == 8'h11) continue;
      d = 8'($random(seed));
      wr(8'(i), d);
      rd(8'(i), d);
    end
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h16, 8'h00);
    // Every skew code
    for (int c = 0; c < 4; c++) begin
      wr(8'h0b, {1'b0, 2'(c), 5'h04});
      repeat (2) @(posedge ref_clk);
      chk_frame({15'h0, (c == 0) ? 2'd1 : 2'(c)}, {15'h0, cursor_skew_q});
    end
    // Frame timing without and with the ninth bits, interrupt enabled then disabled
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h03);
    wr(8'h14, 8'h02);
    wr(8'h0c, 8'h12);
    wr(8'h0d, 8'h34);
    for (int k = 0; k < 2; k++) begin
      wr(8'h07, k ? 8'h1f : 8'h10);
      wr(8'h10, 8'h0d);
      wr(8'h11, k ? 8'h38 : 8'h18);
      wr(8'h12, 8'h0a);
      wr(8'h15, 8'h0c);
      vtotal_low <= k ? 8'h10 : 8'h1e;
      wait_vr(1'b1);
      wait_vr(1'b0);
      q_rise.push_back({k ? 9'h10d : 9'h00d, 5'd3, ~1'(k), 1'b1, 1'b0});
      q_fall.push_back(17'h8);
      wait_vr(1'b1);
      wait_vr(1'b0);
      wr(8'h11, 8'h08);
      repeat (2) @(posedge ref_clk);
      chk_frame(17'h0, {16'h0, frame_interrupt_output_q});
    end
    // Freeze the line model just after a frame wrap so the refresh address holds still
    @(negedge ref_clk);
    while (scan_line_q === 9'h0) @(negedge ref_clk);
    while (scan_line_q !== 9'h0) @(negedge ref_clk);
    @(posedge ref_clk);
    run <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_frame({1'h0, 16'h2468}, {1'h0, mem_addr_q});
    mode_byte_mode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_frame({1'h0, 16'h48d0}, {1'h0, mem_addr_q});
    mode_byte_mode <= 1'b1;
    // Frozen on row 2 at byte address 2468h: cursor rows 2..2 at word 1234h, underline on row 2
    wr(8'h0a, 8'h02);
    wr(8'h0b, 8'h03);
    wr(8'h0e, 8'h12);
    wr(8'h0f, 8'h34);
    repeat (2) @(posedge ref_clk);
    chk_frame(17'h1, {16'h0, cursor_hit_q});
    chk_frame(17'h1, {16'h0, underline_hit_q});
    wr(8'h0b, 8'h02);
    repeat (2) @(posedge ref_clk);
    chk_frame(17'h0, {16'h0, cursor_hit_q});
    wr(8'h0b, 8'h03);
    wr(8'h0a, 8'h03);
    repeat (2) @(posedge ref_clk);
    chk_frame(17'h0, {16'h0, cursor_hit_q});
    pen_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    pen_req <= 1'b0;
    rd(8'h10, 8'h24);
    rd(8'h11, 8'h68);
    ext_enable <= 1'b1;
    rd(8'h10, 8'h0d);
    rd(8'h11, 8'h08);
    ext_enable <= 1'b0;
    run <= 1'b1;
    repeat (4) @(posedge ref_clk);
    test_done();
  end
endmodule : cvc_core_tb

/* tb/cvc_hsync_model.sv */
// Stand-in for the horizontal timing and light pen that feed the vertical core.
// Assumes a single ref_clk domain; the bench raises the pen pin through pen_req.
module cvc_hsync_model
  import cvc_pkg::*;
#(
  parameter int LINE_LEN = 16
) (
  // Clock and control from the bench
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic pen_req,
  // Toward the core
  output logic      line_tick,
  output logic      char_tick,
  output logic      light_pen_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned pos = 0;

  initial begin
    line_tick = 1'b0;
    char_tick = 1'b0;
    light_pen_strobe = 1'b0;
  end

  // One line pulse per line; characters start late so the row address settles first
  always @(posedge ref_clk) begin
    pos <= (pos == LINE_LEN - 1) ? 0 : pos + 1;
    line_tick <= run && (pos == 0);
    char_tick <= run && (pos >= 4) && (pos < 12);
    light_pen_strobe <= pen_req; // Level held as long as the bench asks
  end
endmodule : cvc_hsync_model
